/* pkg/rgc_pkg.sv */
// constants shared by the receiver gain control register bank
package rgc_pkg;
  // ********************
  // register offsets
  // ********************
  localparam logic [5:0] RGC_ADDR_CTRL = 6'h23;
  localparam logic [5:0] RGC_ADDR_THR  = 6'h24;
  localparam logic [5:0] RGC_ADDR_CFG  = 6'h25;
  localparam logic [5:0] RGC_ADDR_STEP = 6'h26;
  // ********************
  // field positions
  // ********************
  localparam int RGC_CTRL_OE_BIT    = 11;
  localparam int RGC_CTRL_GAIN_LSB  = 4;
  localparam int RGC_CTRL_OVR_LSB   = 2;
  localparam int RGC_THR_HYST_LSB   = 12;
  localparam int RGC_THR_HIGH_LSB   = 6;
  localparam int RGC_CFG_BLANK_BIT  = 14;
  localparam int RGC_CFG_BOOST_BIT  = 13;
  localparam int RGC_CFG_SETTLE_LSB = 11;
  localparam int RGC_CFG_PEAK_LSB   = 8;
  localparam int RGC_CFG_WIN_LSB    = 6;
  localparam int RGC_STEP_M2H_LSB   = 5;
  // ********************
  // values after reset
  // ********************
  localparam logic [6:0] RGC_RST_GAIN   = 7'h7f;
  localparam logic [3:0] RGC_RST_HYST   = 4'h3;
  localparam logic [5:0] RGC_RST_THR_H  = 6'h19;
  localparam logic [5:0] RGC_RST_THR_L  = 6'h09;
  localparam logic [1:0] RGC_RST_SETTLE = 2'h1;
  localparam logic [1:0] RGC_RST_WIN    = 2'h1;
  localparam logic [5:0] RGC_RST_TARGET = 6'h14;
  localparam logic [4:0] RGC_RST_M2H    = 5'h09;
  localparam logic [4:0] RGC_RST_L2M    = 5'h0a;
  // ********************
  // mode codes and loop constants
  // ********************
  localparam logic [1:0] RGC_MODE_AUTO = 2'h0;
  localparam logic [1:0] RGC_MODE_LOW  = 2'h1;
  localparam logic [1:0] RGC_MODE_MID  = 2'h2;
  localparam logic [1:0] RGC_MODE_HIGH = 2'h3;
  // one 14 dB stage in gain codes of 2 dB
  localparam logic [6:0] RGC_STAGE_CODES = 7'h07;
  localparam int         RGC_WIN_BASE_SHIFT = 3;
  localparam logic [2:0] RGC_SETTLE_BASE = 3'h1;
endpackage

/* logic/rgc_avg.sv */
// accumulate-and-dump averager of the received level
`timescale 1ns/1ns
module rgc_avg
  import rgc_pkg::*;
#(
  parameter int LEVEL_W = 6
) (
  input  wire logic               clock_in,
  input  wire logic               rst_in,
  input  wire logic               sample_valid_in,
  input  wire logic [LEVEL_W-1:0] sample_level_in,
  input  wire logic [1:0]         win_code_in,
  output logic      [LEVEL_W-1:0] avg_out,
  output logic                    avg_valid_out
);
  localparam int ACC_W = LEVEL_W + 6;
  logic [ACC_W-1:0]   acc_reg,   acc_next;
  logic [6:0]         cnt_reg,   cnt_next;
  logic [LEVEL_W-1:0] avg_reg,   avg_next;
  logic               vld_reg,   vld_next;
  logic [6:0]         win_len;
  logic [ACC_W-1:0]   acc_sum;

  always_comb begin
    win_len  = 7'(8 << win_code_in);
    acc_sum  = acc_reg + ACC_W'(sample_level_in);
    acc_next = acc_reg;
    cnt_next = cnt_reg;
    avg_next = avg_reg;
    vld_next = 1'b0;
    if (sample_valid_in) begin
      if (cnt_reg + 7'h01 >= win_len) begin
        // dump: divide by the window length with a shift
        avg_next = LEVEL_W'(acc_sum >> (RGC_WIN_BASE_SHIFT + int'(win_code_in)));
        vld_next = 1'b1;
        acc_next = '0;
        cnt_next = '0;
      end else begin
        acc_next = acc_sum;
        cnt_next = cnt_reg + 7'h01;
      end
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      acc_reg <= '0;
      cnt_reg <= '0;
      avg_reg <= '0;
      vld_reg <= 1'b0;
    end else begin
      acc_reg <= acc_next;
      cnt_reg <= cnt_next;
      avg_reg <= avg_next;
      vld_reg <= vld_next;
    end
  end

  assign avg_out       = avg_reg;
  assign avg_valid_out = vld_reg;

  a_dump_spacing: assert property (@(posedge clock_in) disable iff (rst_in)
    avg_valid_out && win_code_in == 2'h0 && $stable(win_code_in) |-> cnt_reg == 7'h00)
    else $error("averager counter not cleared at dump");
endmodule

/* logic/rgc_mode_sel.sv */
// front-end gain mode choice with hysteresis
`timescale 1ns/1ns
module rgc_mode_sel
  import rgc_pkg::*;
(
  input  wire logic       clock_in,
  input  wire logic       rst_in,
  input  wire logic       eval_in,
  input  wire logic [6:0] gain_in,
  input  wire logic [5:0] thr_low_in,
  input  wire logic [5:0] thr_high_in,
  input  wire logic [3:0] hyst_in,
  output logic      [1:0] mode_out,
  output logic            up_out,
  output logic            down_out
);
  typedef enum logic [1:0] {MS_LOW, MS_MID, MS_HIGH} rgc_ms_t;
  rgc_ms_t    st_reg, st_next;
  logic       up_reg, up_next;
  logic       dn_reg, dn_next;
  logic [7:0] g_lo, g_hi, hi_up, hi_dn, lo_up, lo_dn;

  always_comb begin
    g_lo  = {1'b0, gain_in} + {4'h0, hyst_in};
    g_hi  = {1'b0, gain_in};
    hi_up = {2'b00, thr_high_in} + {4'h0, hyst_in};
    hi_dn = {2'b00, thr_high_in};
    lo_up = {2'b00, thr_low_in} + {4'h0, hyst_in};
    lo_dn = {2'b00, thr_low_in};
    st_next = st_reg;
    up_next = 1'b0;
    dn_next = 1'b0;
    if (eval_in) begin
      // a little vga gain left means a strong signal: drop front-end gain
      unique case (st_reg)
        MS_HIGH: if (g_lo < hi_dn) begin st_next = MS_MID; dn_next = 1'b1; end
        MS_MID: begin
          if (g_hi > hi_up) begin
            st_next = MS_HIGH;
            up_next = 1'b1;
          end else if (g_lo < lo_dn) begin
            st_next = MS_LOW;
            dn_next = 1'b1;
          end
        end
        MS_LOW:  if (g_hi > lo_up) begin st_next = MS_MID; up_next = 1'b1; end
        default: st_next = MS_HIGH;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      st_reg <= MS_HIGH;
      up_reg <= 1'b0;
      dn_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      up_reg <= up_next;
      dn_reg <= dn_next;
    end
  end

  assign mode_out = (st_reg == MS_LOW) ? RGC_MODE_LOW : (st_reg == MS_MID) ? RGC_MODE_MID : RGC_MODE_HIGH;
  assign up_out   = up_reg;
  assign down_out = dn_reg;

  a_hyst_hold: assert property (@(posedge clock_in) disable iff (rst_in)
    eval_in && st_reg == MS_HIGH && g_lo >= hi_dn |=> st_reg == MS_HIGH && !down_out)
    else $error("mode left high without crossing by the hysteresis");
endmodule

/* logic/rgc_regs.sv */
// receiver gain control registers and gain loop
//
// What this block does
// - override bit applies manual amplifier gain
// - gain field writes manual, reads gain used
// - front-end override: auto, low, mid, high
// - status shows front-end mode in effect
// - four-bit mode hysteresis, 2 dB, reset 3
// - mid/high switch level, reset 25
// - low/mid switch level, reset 9
// - blanking select chooses when amplifier blanks
// - settle wait after gain change, reset 1
// - three peak detector enables, one each
// - averaging window 8 to 64 samples
// - loop target level, 2 dB, reset 20
// - mid to high gain step, reset 9
// - low to mid gain step, reset 10
`timescale 1ns/1ns
module rgc_regs
  import rgc_pkg::*;
#(
  parameter int LEVEL_W = 6
) (
  input  wire logic               clock_in,
  input  wire logic               rst_in,
  input  wire logic [5:0]         reg_addr_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  input  wire logic [15:0]        reg_wdata_in,
  input  wire logic               rx_active_in,
  input  wire logic               sample_valid_in,
  input  wire logic [LEVEL_W-1:0] sample_level_in,
  input  wire logic [2:0]         peak_hit_in,
  output logic      [15:0]        reg_rdata_out,
  output logic      [6:0]         vga_gain_out,
  output logic      [1:0]         frontend_mode_out,
  output logic                    blank_out,
  output logic      [2:0]         peak_enable_out,
  output logic                    peak_boost_out
);
  // ********************
  // register file
  // ********************
  logic        gain_oe_reg,      gain_oe_next;
  logic [6:0]  manual_gain_reg,  manual_gain_next;
  logic [1:0]  mode_ovr_reg,     mode_ovr_next;
  logic [3:0]  hyst_reg,         hyst_next;
  logic [5:0]  thr_h_reg,        thr_h_next;
  logic [5:0]  thr_l_reg,        thr_l_next;
  logic        blank_sel_reg,    blank_sel_next;
  logic        boost_reg,        boost_next;
  logic [1:0]  settle_reg,       settle_next;
  logic [2:0]  peak_sel_reg,     peak_sel_next;
  logic [1:0]  win_reg,          win_next;
  logic [5:0]  target_reg,       target_next;
  logic [4:0]  m2h_reg,          m2h_next;
  logic [4:0]  l2m_reg,          l2m_next;
  logic [15:0] rdata_reg,        rdata_next;
  // ********************
  // loop state
  // ********************
  logic [6:0]  agc_gain_reg,     agc_gain_next;
  logic [6:0]  used_gain_reg,    used_gain_next;
  logic [1:0]  mode_stat_reg,    mode_stat_next;
  logic [2:0]  settle_cnt_reg,   settle_cnt_next;
  logic        peak_seen_reg,    peak_seen_next;
  logic        blank_reg,        blank_next;
  logic        eval_reg,         eval_next;
  logic [2:0]  peak_s1_reg,      peak_s2_reg;
  logic [LEVEL_W-1:0] avg_level;
  logic        avg_valid;
  logic [1:0]  sel_mode;
  logic        sel_up,           sel_down;
  logic        peak_hit;
  logic signed [8:0] sum;
  logic [6:0]  step;

  always_comb begin
    gain_oe_next     = gain_oe_reg;
    manual_gain_next = manual_gain_reg;
    mode_ovr_next    = mode_ovr_reg;
    hyst_next        = hyst_reg;
    thr_h_next       = thr_h_reg;
    thr_l_next       = thr_l_reg;
    blank_sel_next   = blank_sel_reg;
    boost_next       = boost_reg;
    settle_next      = settle_reg;
    peak_sel_next    = peak_sel_reg;
    win_next         = win_reg;
    target_next      = target_reg;
    m2h_next         = m2h_reg;
    l2m_next         = l2m_reg;
    rdata_next       = rdata_reg;
    // reserved bits are dropped on write; software keeps them zero
    if (reg_wr_in) begin
      unique case (reg_addr_in)
        RGC_ADDR_CTRL: begin
          gain_oe_next     = reg_wdata_in[RGC_CTRL_OE_BIT];
          manual_gain_next = reg_wdata_in[RGC_CTRL_GAIN_LSB +: 7];
          mode_ovr_next    = reg_wdata_in[RGC_CTRL_OVR_LSB +: 2];
        end
        RGC_ADDR_THR: begin
          hyst_next  = reg_wdata_in[RGC_THR_HYST_LSB +: 4];
          thr_h_next = reg_wdata_in[RGC_THR_HIGH_LSB +: 6];
          thr_l_next = reg_wdata_in[5:0];
        end
        RGC_ADDR_CFG: begin
          blank_sel_next = reg_wdata_in[RGC_CFG_BLANK_BIT];
          boost_next     = reg_wdata_in[RGC_CFG_BOOST_BIT];
          settle_next    = reg_wdata_in[RGC_CFG_SETTLE_LSB +: 2];
          peak_sel_next  = reg_wdata_in[RGC_CFG_PEAK_LSB +: 3];
          win_next       = reg_wdata_in[RGC_CFG_WIN_LSB +: 2];
          target_next    = reg_wdata_in[5:0];
        end
        RGC_ADDR_STEP: begin
          m2h_next = reg_wdata_in[RGC_STEP_M2H_LSB +: 5];
          l2m_next = reg_wdata_in[4:0];
        end
        default: ;
      endcase
    end
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        RGC_ADDR_CTRL: rdata_next = {4'h0, gain_oe_reg, used_gain_reg, mode_ovr_reg, mode_stat_reg};
        RGC_ADDR_THR:  rdata_next = {hyst_reg, thr_h_reg, thr_l_reg};
        RGC_ADDR_CFG:  rdata_next = {1'b0, blank_sel_reg, boost_reg, settle_reg, peak_sel_reg, win_reg, target_reg};
        RGC_ADDR_STEP: rdata_next = {6'h00, m2h_reg, l2m_reg};
        default:       rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      gain_oe_reg     <= 1'b0;
      manual_gain_reg <= RGC_RST_GAIN;
      mode_ovr_reg    <= RGC_MODE_AUTO;
      hyst_reg        <= RGC_RST_HYST;
      thr_h_reg       <= RGC_RST_THR_H;
      thr_l_reg       <= RGC_RST_THR_L;
      blank_sel_reg   <= 1'b0;
      boost_reg       <= 1'b0;
      settle_reg      <= RGC_RST_SETTLE;
      peak_sel_reg    <= 3'h0;
      win_reg         <= RGC_RST_WIN;
      target_reg      <= RGC_RST_TARGET;
      m2h_reg         <= RGC_RST_M2H;
      l2m_reg         <= RGC_RST_L2M;
      rdata_reg       <= 16'h0000;
    end else begin
      gain_oe_reg     <= gain_oe_next;
      manual_gain_reg <= manual_gain_next;
      mode_ovr_reg    <= mode_ovr_next;
      hyst_reg        <= hyst_next;
      thr_h_reg       <= thr_h_next;
      thr_l_reg       <= thr_l_next;
      blank_sel_reg   <= blank_sel_next;
      boost_reg       <= boost_next;
      settle_reg      <= settle_next;
      peak_sel_reg    <= peak_sel_next;
      win_reg         <= win_next;
      target_reg      <= target_next;
      m2h_reg         <= m2h_next;
      l2m_reg         <= l2m_next;
      rdata_reg       <= rdata_next;
    end
  end

  // ********************
  // peak detector synchroniser
  // ********************
  // detector flags come from the analog chain, asynchronous to this clock
  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      peak_s1_reg <= 3'h0;
      peak_s2_reg <= 3'h0;
    end else begin
      peak_s1_reg <= peak_hit_in;
      peak_s2_reg <= peak_s1_reg;
    end
  end
  assign peak_hit = |(peak_s2_reg & peak_sel_reg);

  rgc_avg #(.LEVEL_W(LEVEL_W)) u_avg (
    .clock_in        (clock_in),
    .rst_in          (rst_in),
    .sample_valid_in (sample_valid_in && rx_active_in),
    .sample_level_in (sample_level_in),
    .win_code_in     (win_reg),
    .avg_out         (avg_level),
    .avg_valid_out   (avg_valid)
  );

  rgc_mode_sel u_mode (
    .clock_in    (clock_in),
    .rst_in      (rst_in),
    .eval_in     (eval_reg),
    .gain_in     (agc_gain_reg),
    .thr_low_in  (thr_l_reg),
    .thr_high_in (thr_h_reg),
    .hyst_in     (hyst_reg),
    .mode_out    (sel_mode),
    .up_out      (sel_up),
    .down_out    (sel_down)
  );

  // ********************
  // gain loop
  // ********************
  always_comb begin
    agc_gain_next   = agc_gain_reg;
    settle_cnt_next = settle_cnt_reg;
    peak_seen_next  = peak_seen_reg | peak_hit;
    eval_next       = 1'b0;
    blank_next      = 1'b0;
    sum             = '0;
    step            = '0;
    if (rx_active_in && avg_valid) begin
      // a peak in the dump cycle is kept for the next window
      peak_seen_next = peak_hit;
      if (settle_cnt_reg != 3'h0) begin
        settle_cnt_next = settle_cnt_reg - 3'h1;
      end else begin
        sum = $signed({2'b00, agc_gain_reg}) + $signed({3'b000, target_reg})
            - $signed({3'b000, avg_level});
        if (peak_seen_reg) begin
          sum = sum - $signed({2'b00, RGC_STAGE_CODES});
        end
        if (sum < 0) begin
          agc_gain_next = 7'h00;
        end else if (sum > 9'sd127) begin
          agc_gain_next = 7'h7f;
        end else begin
          agc_gain_next = sum[6:0];
        end
        eval_next = (mode_ovr_reg == RGC_MODE_AUTO);
        if (agc_gain_next != agc_gain_reg) begin
          settle_cnt_next = {1'b0, settle_reg} + RGC_SETTLE_BASE;
        end
        // losing a whole stage or more counts as switching it out
        // one bit wider so a new gain near the top cannot wrap and fake a stage drop
        blank_next = ({1'b0, agc_gain_reg} >= {1'b0, agc_gain_next} + {1'b0, RGC_STAGE_CODES})
                   && !blank_sel_reg;
      end
    end else if (sel_up || sel_down) begin
      // front-end gain moved: give the opposite step to the amplifier
      step = (sel_mode == RGC_MODE_HIGH || (sel_down && sel_mode == RGC_MODE_MID))
           ? {2'b00, m2h_reg} : {2'b00, l2m_reg};
      if (sel_up) begin
        agc_gain_next = (agc_gain_reg > step) ? agc_gain_reg - step : 7'h00;
      end else begin
        agc_gain_next = (7'h7f - agc_gain_reg > step) ? agc_gain_reg + step : 7'h7f;
      end
      settle_cnt_next = {1'b0, settle_reg} + RGC_SETTLE_BASE;
    end
    used_gain_next = gain_oe_reg ? manual_gain_reg : agc_gain_reg;
    mode_stat_next = (mode_ovr_reg != RGC_MODE_AUTO) ? mode_ovr_reg : sel_mode;
    if (gain_oe_reg) begin
      blank_next = blank_sel_reg && rx_active_in;
    end
  end

  always_ff @(posedge clock_in or posedge rst_in) begin
    if (rst_in) begin
      agc_gain_reg   <= RGC_RST_GAIN;
      used_gain_reg  <= RGC_RST_GAIN;
      mode_stat_reg  <= RGC_MODE_HIGH;
      settle_cnt_reg <= 3'h0;
      peak_seen_reg  <= 1'b0;
      blank_reg      <= 1'b0;
      eval_reg       <= 1'b0;
    end else begin
      agc_gain_reg   <= agc_gain_next;
      used_gain_reg  <= used_gain_next;
      mode_stat_reg  <= mode_stat_next;
      settle_cnt_reg <= settle_cnt_next;
      peak_seen_reg  <= peak_seen_next;
      blank_reg      <= blank_next;
      eval_reg       <= eval_next;
    end
  end

  assign reg_rdata_out     = rdata_reg;
  assign vga_gain_out      = used_gain_reg;
  assign frontend_mode_out = mode_stat_reg;
  assign blank_out         = blank_reg;
  assign peak_enable_out   = peak_sel_reg;
  assign peak_boost_out    = boost_reg;

  // ********************
  // checks
  // ********************
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);

  sequence s_wr(logic [5:0] a);
    reg_wr_in && reg_addr_in == a;
  endsequence

  a_manual_gain: assert property (gain_oe_reg && !reg_wr_in ##1 gain_oe_reg |-> vga_gain_out == $past(manual_gain_reg))
    else $error("manual gain not applied under override");
  a_gain_readback: assert property (reg_rd_in && reg_addr_in == RGC_ADDR_CTRL |=>
    reg_rdata_out[10:4] == $past(used_gain_reg) && reg_rdata_out[15:12] == 4'h0)
    else $error("gain readback differs from gain in use");
  a_mode_forced: assert property (mode_ovr_reg != RGC_MODE_AUTO ##1 $stable(mode_ovr_reg) |->
    frontend_mode_out == mode_ovr_reg)
    else $error("front-end override not applied");
  a_status_read: assert property (reg_rd_in && reg_addr_in == RGC_ADDR_CTRL |=>
    reg_rdata_out[1:0] == $past(frontend_mode_out))
    else $error("mode status does not match mode in effect");
  a_thr_store: assert property (s_wr(RGC_ADDR_THR) |=> hyst_reg == $past(reg_wdata_in[15:12])
    && thr_h_reg == $past(reg_wdata_in[11:6]) && thr_l_reg == $past(reg_wdata_in[5:0]))
    else $error("threshold register not stored");
  a_blank_never: assert property (!gain_oe_reg && blank_sel_reg ##1 !gain_oe_reg |-> !blank_out)
    else $error("blanking while blanking disabled");
  a_blank_forced: assert property (gain_oe_reg && blank_sel_reg && rx_active_in |=> blank_out)
    else $error("override blanking not performed");
  a_settle_hold: assert property (settle_cnt_reg != 3'h0 && avg_valid && rx_active_in |=>
    agc_gain_reg == $past(agc_gain_reg))
    else $error("gain changed while settling");
  a_cfg_store: assert property (s_wr(RGC_ADDR_CFG) |=> peak_enable_out == $past(reg_wdata_in[10:8])
    && win_reg == $past(reg_wdata_in[7:6]) && target_reg == $past(reg_wdata_in[5:0]))
    else $error("loop config register not stored");
  a_step_store: assert property (s_wr(RGC_ADDR_STEP) |=> m2h_reg == $past(reg_wdata_in[9:5])
    && l2m_reg == $past(reg_wdata_in[4:0]))
    else $error("mode step register not stored");
endmodule

/* sim/rgc_regs_tb.sv */
// self-checking bench for the receiver gain control register bank
`timescale 1ns/1ns
module rgc_regs_tb
  import rgc_pkg::*;
;
  typedef struct {
    logic [5:0]  a;
    logic        w;
    logic [15:0] d;
    logic [15:0] e;
  } rgc_row_t;

  logic        clock_in        = 1'b0;
  logic        rst_in          = 1'b1;
  logic [5:0]  reg_addr_in     = 6'h00;
  logic        reg_wr_in       = 1'b0;
  logic        reg_rd_in       = 1'b0;
  logic [15:0] reg_wdata_in    = 16'h0000;
  logic        rx_active_in    = 1'b0;
  logic        sample_valid_in = 1'b0;
  logic [5:0]  sample_level_in = 6'h00;
  logic [2:0]  peak_hit_in     = 3'h0;
  logic [15:0] reg_rdata_out;
  logic [6:0]  vga_gain_out;
  logic [1:0]  frontend_mode_out;
  logic        blank_out;
  logic [2:0]  peak_enable_out;
  logic        peak_boost_out;
  logic        seen_blank      = 1'b0;
  int          fails           = 0;
  int          n_checks        = 0;

  // ********************
  // ordinary cases: optional write, then read back
  // ********************
  rgc_row_t rows [13] = '{
    '{6'h23, 1'b0, 16'h0000, 16'h07f3},
    '{6'h24, 1'b0, 16'h0000, 16'h3649},
    '{6'h25, 1'b0, 16'h0000, 16'h0854},
    '{6'h26, 1'b0, 16'h0000, 16'h012a},
    '{6'h27, 1'b1, 16'h0fff, 16'h0000},
    '{6'h24, 1'b1, 16'hffff, 16'hffff},
    '{6'h25, 1'b1, 16'h7fff, 16'h7fff},
    '{6'h26, 1'b1, 16'h03ff, 16'h03ff},
    '{6'h23, 1'b1, 16'h0004, 16'h07f5},
    '{6'h23, 1'b1, 16'h0008, 16'h07fa},
    '{6'h23, 1'b1, 16'h000c, 16'h07ff},
    '{6'h23, 1'b1, 16'h0000, 16'h07f3},
    '{6'h23, 1'b1, 16'h0a58, 16'h0a5a}
  };

  rgc_regs rgc_regs_inst (
    .clock_in          (clock_in),
    .rst_in            (rst_in),
    .reg_addr_in       (reg_addr_in),
    .reg_wr_in         (reg_wr_in),
    .reg_rd_in         (reg_rd_in),
    .reg_wdata_in      (reg_wdata_in),
    .rx_active_in      (rx_active_in),
    .sample_valid_in   (sample_valid_in),
    .sample_level_in   (sample_level_in),
    .peak_hit_in       (peak_hit_in),
    .reg_rdata_out     (reg_rdata_out),
    .vga_gain_out      (vga_gain_out),
    .frontend_mode_out (frontend_mode_out),
    .blank_out         (blank_out),
    .peak_enable_out   (peak_enable_out),
    .peak_boost_out    (peak_boost_out)
  );

  always #50 clock_in = ~clock_in;

  // ********************
  // shared tasks
  // ********************
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge clock_in);
    reg_addr_in  <= a;
    reg_wdata_in <= d;
    reg_wr_in    <= 1'b1;
    @(posedge clock_in);
    reg_wr_in    <= 1'b0;
  endtask

  // read data lands one cycle after the strobe edge, so look at the falling edge
  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_rd_in   <= 1'b1;
    @(posedge clock_in);
    reg_rd_in   <= 1'b0;
    @(negedge clock_in);
    chk(reg_rdata_out, e);
  endtask

  // one eight-sample window; the peak flag drops early so none is left for the next window
  task automatic win8(input logic [5:0] lvl, input logic [2:0] pk);
    @(posedge clock_in);
    sample_level_in <= lvl;
    sample_valid_in <= 1'b1;
    peak_hit_in     <= pk;
    repeat (4) @(posedge clock_in);
    peak_hit_in     <= 3'h0;
    repeat (4) @(posedge clock_in);
    sample_valid_in <= 1'b0;
    repeat (4) @(posedge clock_in);
    @(negedge clock_in);
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  initial begin
    repeat (3) @(posedge clock_in);
    rst_in <= 1'b0;
    foreach (rows[i]) begin
      if (rows[i].w) begin
        wr(rows[i].a, rows[i].d);
      end
      rd(rows[i].a, rows[i].e);
      if (rows[i].a == RGC_ADDR_CTRL) begin
        chk({14'h0, frontend_mode_out}, {14'h0, rows[i].e[1:0]});
        chk({9'h0, vga_gain_out}, {9'h0, rows[i].e[10:4]});
      end
      if (rows[i].a == RGC_ADDR_CFG) begin
        chk({12'h0, peak_boost_out, peak_enable_out}, {12'h0, rows[i].e[13], rows[i].e[10:8]});
      end
    end
    // ********************
    // override on, select bit set: blanking on during reception, off after it
    // ********************
    @(posedge clock_in);
    rx_active_in <= 1'b1;
    repeat (2) @(negedge clock_in);
    chk({15'h0, blank_out}, 16'h0001);
    chk({9'h0, vga_gain_out}, 16'h0025);
    @(posedge clock_in);
    rx_active_in <= 1'b0;
    repeat (2) @(negedge clock_in);
    chk({15'h0, blank_out}, 16'h0000);
    // ********************
    // reset in mid-run restores the defaults
    // ********************
    @(posedge clock_in);
    rst_in <= 1'b1;
    repeat (2) @(negedge clock_in);
    chk({9'h0, vga_gain_out}, {9'h0, RGC_RST_GAIN});
    chk({14'h0, frontend_mode_out}, 16'h0003);
    @(posedge clock_in);
    rst_in <= 1'b0;
    rd(RGC_ADDR_CFG, 16'h0854);
    // ********************
    // loop: eight-sample window, average above target lowers gain
    // ********************
    wr(RGC_ADDR_CFG, 16'h0014);
    @(posedge clock_in);
    rx_active_in    <= 1'b1;
    sample_level_in <= 6'h1e;
    sample_valid_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    sample_valid_in <= 1'b0;
    // blank is a one-cycle pulse, so every cycle is watched
    repeat (20) begin
      @(negedge clock_in);
      if (blank_out === 1'b1) begin
        seen_blank = 1'b1;
      end
    end
    // gain + target - average = 127 + 20 - 30
    chk({9'h0, vga_gain_out}, 16'h0075);
    chk({15'h0, seen_blank}, 16'h0001);
    chk({14'h0, frontend_mode_out}, 16'h0003);
    // ********************
    // settle skip, enabled peak detector, then a front-end mode drop
    // ********************
    wr(RGC_ADDR_CFG, 16'h0114);
    win8(6'h1e, 3'h0);
    chk({9'h0, vga_gain_out}, 16'h0075);
    win8(6'h1e, 3'h1);
    // a stage comes off for the peak: 117 + 20 - 30 - 7
    chk({9'h0, vga_gain_out}, 16'h0064);
    win8(6'h3f, 3'h0);
    win8(6'h3f, 3'h0);
    chk({9'h0, vga_gain_out}, 16'h0039);
    chk({14'h0, frontend_mode_out}, 16'h0003);
    win8(6'h3f, 3'h0);
    win8(6'h3f, 3'h0);
    // 14 + 3 falls under 25: mid mode, gain raised by the mid to high step
    chk({9'h0, vga_gain_out}, 16'h0017);
    chk({14'h0, frontend_mode_out}, 16'h0002);
    test_done();
  end
endmodule
